// ===== sim/peripheral_io_bus_test.sv
// Testbench joining console and card ends of the expansion bus.
`timescale 1ns/1ps
`include "pio_regs.svh"
module peripheral_io_bus_test;
    logic        mclk, arst_n, req, req_rd, req_ser, req_ready, done;
    logic [15:0] req_addr, req_wdata, rdata;
    logic        sys_int_n, irq, spk_seen;
    logic [3:0]  card_slot;
    logic [7:0]  ser_bits;
    logic [7:0]  pat;
    logic [15:0] wq[$];
    int          error_cnt, cmp_count;

    pio_bus_if pio_bus_if_i ();
    pio_console pio_console_i (.mclk(mclk), .arst_n(arst_n), .req(req),
        .req_rd(req_rd), .req_ser(req_ser), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .done(done),
        .rdata(rdata), .sys_int_n(sys_int_n), .bus(pio_bus_if_i));
    pio_card pio_card_i (.mclk(mclk), .arst_n(arst_n),
        .card_slot(card_slot), .irq(irq), .ser_bits(ser_bits),
        .bus(pio_bus_if_i));
    pio_bus_asserts pio_bus_asserts_i (.mclk(mclk), .arst_n(arst_n),
        .addr(pio_bus_if_i.addr),
        .memory_cycle_enable_n(pio_bus_if_i.memory_cycle_enable_n),
        .data_bus_in_strobe(pio_bus_if_i.data_bus_in_strobe),
        .write_strobe_n(pio_bus_if_i.write_strobe_n),
        .peripheral_block_select_n(pio_bus_if_i.peripheral_block_select_n),
        .speech_block_select_n(pio_bus_if_i.speech_block_select_n),
        .serial_io_strobe_n(pio_bus_if_i.serial_io_strobe_n),
        .data_per_oe(pio_bus_if_i.data_per_oe));

    // Free running 50 MHz clock.
    always #10 mclk = ~mclk;

    // Records each byte as the write strobe falls, with the low address bit.
    always @(negedge pio_bus_if_i.write_strobe_n) begin
        wq.push_back({7'h00, pio_bus_if_i.addr[0], pio_bus_if_i.data_con_o});
    end

    // Notes any speech select seen at a sampling edge.
    always @(posedge mclk) begin
        if (pio_bus_if_i.speech_block_select_n === 1'b0) begin
            spk_seen <= 1'b1;
        end
    end

    // Compares one value and reports a difference at once.
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One processor request; entered at a falling edge, waits for done.
    task automatic access(input logic rd, input logic ser,
                          input logic [15:0] a, input logic [15:0] wd);
        int n;
        int exp_n;
        exp_n = ser ? `PIO_SER_CYC + 1 : 2 * `PIO_BYTE_CYC + 1;
        if (!rd && !ser) begin
            exp_n += `PIO_ALU_CYC;
        end
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        req = 1'b1;
        req_rd = rd;
        req_ser = ser;
        req_addr = a;
        req_wdata = wd;
        @(negedge mclk);
        req = 1'b0;
        check("busy", 16'h0000, {15'h0000, req_ready});
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        check("done seen", 16'h0001, {15'h0000, done});
        check("cycles", 16'(exp_n), 16'(n));
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Cuts a hang short; all tests need far fewer cycles than this.
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        {req, req_rd, req_ser, irq, spk_seen} = 5'h00;
        req_addr = 16'h0000;
        req_wdata = 16'h0000;
        card_slot = 4'h3;
        pat = 8'hb4;
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        // Word write: odd byte with low half first, then read back.
        access(1'b0, 1'b0, 16'h4002, 16'ha55a);
        check("first byte", 16'h015a, wq[0]);
        check("second byte", 16'h00a5, wq[1]);
        access(1'b0, 1'b0, 16'h4004, 16'h1234);
        access(1'b1, 1'b0, 16'h4002, 16'h0000);
        check("word 4002", 16'ha55a, rdata);
        access(1'b1, 1'b0, 16'h4004, 16'h0000);
        check("word 4004", 16'h1234, rdata);
        $display("Test word access ended.");
        // Speech select on its two addresses and not elsewhere.
        spk_seen = 1'b0;
        access(1'b0, 1'b0, 16'h9000, 16'h00ff);
        check("speech write", 16'h0001, {15'h0000, spk_seen});
        spk_seen = 1'b0;
        access(1'b1, 1'b0, 16'h9400, 16'h0000);
        check("speech read", 16'h0001, {15'h0000, spk_seen});
        spk_seen = 1'b0;
        access(1'b1, 1'b0, 16'h4000, 16'h0000);
        check("speech idle", 16'h0000, {15'h0000, spk_seen});
        $display("Test speech select ended.");
        // Serial bits to the card in slot 3, then to foreign blocks.
        for (int k = 0; k < 8; k++) begin
            access(1'b0, 1'b1, 16'h0980 + 16'(k), {15'h0000, pat[k]});
        end
        check("serial bits", {8'h00, pat}, {8'h00, ser_bits});
        access(1'b0, 1'b1, 16'h0a00, 16'h0001);
        access(1'b0, 1'b1, 16'h0400, 16'h0001);
        check("foreign bits", {8'h00, pat}, {8'h00, ser_bits});
        for (int k = 0; k < 8; k++) begin
            access(1'b1, 1'b1, 16'h0980 + 16'(k), 16'h0000);
            check("serial in", {15'h0000, pat[k]}, {15'h0000, rdata[0]});
        end
        $display("Test serial bits ended.");
        // Card interrupt reaches the maskable input.
        irq = 1'b1;
        @(negedge mclk);
        check("irq set", 16'h0000, {15'h0000, sys_int_n});
        irq = 1'b0;
        @(negedge mclk);
        check("irq clear", 16'h0001, {15'h0000, sys_int_n});
        $display("Test interrupt ended.");
        print_verdict();
    end
endmodule

// ===== sim/pio_bus_asserts.sv
// Concurrent checks on the expansion bus wires between both ends.
`timescale 1ns/1ps
module pio_bus_asserts (
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        arst_n,
    // Expansion bus wires.
    input wire logic [15:0] addr,
    input wire logic        memory_cycle_enable_n,
    input wire logic        data_bus_in_strobe,
    input wire logic        write_strobe_n,
    input wire logic        peripheral_block_select_n,
    input wire logic        speech_block_select_n,
    input wire logic        serial_io_strobe_n,
    input wire logic        data_per_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    logic [7:0] wlow_q;

    // Counts low cycles of the write strobe; avoids a long repetition.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wlow_q <= 8'h00;
        end else if (!write_strobe_n) begin
            wlow_q <= wlow_q + 8'h01;
        end else begin
            wlow_q <= 8'h00;
        end
    end

    rd_wstb_high_a: assert property (
        data_bus_in_strobe |-> write_strobe_n)
        else $error("Write strobe low during a read cycle.");
    addr_settle_a: assert property (
        $fell(memory_cycle_enable_n) |-> ##1 $stable(addr)[*5])
        else $error("Address moved inside the settle time.");
    rd_select_time_a: assert property (
        $fell(memory_cycle_enable_n) && data_bus_in_strobe && addr[0]
        && addr[15:13] == 3'h2
        |-> peripheral_block_select_n[*8] ##1 !peripheral_block_select_n)
        else $error("Block select not at phase two of cycle one.");
    wstb_width_a: assert property (
        $rose(write_strobe_n) |-> wlow_q == 8'h20)
        else $error("Write strobe low time is wrong.");
    wr_select_held_a: assert property (
        !write_strobe_n && addr[15:13] == 3'h2
        |-> !peripheral_block_select_n && !memory_cycle_enable_n)
        else $error("Block select dropped during a write.");
    second_sel_a: assert property (
        !memory_cycle_enable_n && !addr[0] && addr[15:13] == 3'h2
        |-> !peripheral_block_select_n)
        else $error("Block select dropped in the second byte.");
    spk_decode_a: assert property (
        !speech_block_select_n |-> addr[15:10] inside {6'h24, 6'h25})
        else $error("Speech select outside its addresses.");
    ser_stb_width_a: assert property (
        $fell(serial_io_strobe_n)
        |-> !serial_io_strobe_n[*4] ##1 serial_io_strobe_n)
        else $error("Serial strobe width is wrong.");
    ser_settle_a: assert property (
        $fell(serial_io_strobe_n) |-> addr == $past(addr, 5))
        else $error("Serial address not settled before strobe.");
    card_drive_a: assert property (
        data_per_oe |-> !peripheral_block_select_n && data_bus_in_strobe)
        else $error("Card drives data while not selected for read.");
endmodule

// ===== src/pio_bus_if.sv
// Expansion bus wires between console and a plug-in card.
`timescale 1ns/1ps
interface pio_bus_if;
    logic [15:0] addr;
    logic        memory_cycle_enable_n;
    logic        data_bus_in_strobe;
    logic        write_strobe_n;
    logic        peripheral_block_select_n;
    logic        speech_block_select_n;
    logic        serial_io_strobe_n;
    logic        serial_io_in;
    logic        external_interrupt_request_n;
    logic [7:0]  data_con_o;
    logic        data_con_oe;
    logic [7:0]  data_per_o;
    logic        data_per_oe;
    modport console (
        output addr, memory_cycle_enable_n, data_bus_in_strobe,
               write_strobe_n, peripheral_block_select_n,
               speech_block_select_n, serial_io_strobe_n,
               data_con_o, data_con_oe,
        input  serial_io_in, external_interrupt_request_n,
               data_per_o, data_per_oe
    );
    modport card (
        input  addr, memory_cycle_enable_n, data_bus_in_strobe,
               write_strobe_n, peripheral_block_select_n,
               speech_block_select_n, serial_io_strobe_n,
               data_con_o, data_con_oe,
        output serial_io_in, external_interrupt_request_n,
               data_per_o, data_per_oe
    );
endinterface

// ===== src/pio_card.sv
// Plug-in card end: small byte memory and one serial bit block.
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_card (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Card identity: which 256-address serial block it owns.
    input  wire logic [3:0] card_slot,
    // User side.
    input  wire logic       irq,
    output logic [7:0]      ser_bits,
    // Expansion bus.
    pio_bus_if.card         bus
);
    typedef struct packed {
        logic [7:0] bits;
        logic       stb_prev;
    } pio_card_t;

    pio_card_t  s_q;
    pio_card_t  s_d;
    logic [7:0] mem [0:15];
    logic       my_ser;

    assign my_ser =
        (bus.addr[`PIO_SER_BASE_HI:`PIO_SER_BASE_LO] == `PIO_SER_PERI)
        && (bus.addr[`PIO_SER_CARD_HI:`PIO_SER_CARD_LO] == card_slot);

    // Latch the serial bit on the strobe's rising edge.
    always_comb begin
        s_d          = s_q;
        s_d.stb_prev = bus.serial_io_strobe_n;
        if (bus.serial_io_strobe_n && !s_q.stb_prev && my_ser) begin
            s_d.bits[bus.addr[3:1]] = bus.addr[0];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= 9'h001;
        end else begin
            s_q <= s_d;
        end
    end

    // Byte memory written while the write strobe is low.
    always_ff @(posedge mclk) begin
        if (!bus.write_strobe_n && !bus.peripheral_block_select_n
            && bus.data_con_oe) begin
            mem[bus.addr[3:0]] <= bus.data_con_o;
        end
    end

    // Drive only while selected and reading; data is ready at once.
    assign bus.data_per_oe = ~bus.peripheral_block_select_n
                             & bus.data_bus_in_strobe;
    assign bus.data_per_o  = mem[bus.addr[3:0]];
    assign bus.serial_io_in = my_ser & s_q.bits[bus.addr[3:1]];
    assign bus.external_interrupt_request_n = ~irq;
    assign ser_bits = s_q.bits;
endmodule

// ===== src/pio_console.sv
// Console end of the expansion bus: byte-split memory and serial cycles.
// How it works
// - Word access becomes two byte cycles, assembled.
// - Odd byte first, even byte second.
// - Read: enable low, data-in high, write high.
// - Address driven with enable, settles 100 ns.
// - Block select asserts at phase two, cycle 1.
// - Card read data valid by 750 ns.
// - Word sampled at phase one of cycle 2.
// - Write preceded by arithmetic cycle, enable asserted; here enable stays high through it.
// - Write strobe low at phase two, 650 ns; here 640 ns, rounded down to whole ticks.
// - Lowest address changes at 990 ns; here at 980 ns, rounded down to whole ticks.
// - Second write byte same; select held throughout.
// - Block 4000-5FFF predecoded as block select.
// - Speech select 9000 write, 9400 read.
// - Serial bits 1000-1FFE belong to cards.
// - Serial output over two cycles, address settles.
// - Serial strobe 80 ns low in cycle 2.
// - Serial output data valid from cycle 1.
// - Serial input sampled at cycle 2 start.
// - Card interrupt routed to a maskable input.
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_console (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Processor side request.
    input  wire logic        req,
    input  wire logic        req_rd,
    input  wire logic        req_ser,
    input  wire logic [15:0] req_addr,
    input  wire logic [15:0] req_wdata,
    output logic             req_ready,
    output logic             done,
    output logic [15:0]      rdata,
    // Maskable interrupt input of the system interface.
    output logic             sys_int_n,
    // Expansion bus.
    pio_bus_if.console       bus
);
    // Whole console state: one copy is computed, one is registered.
    typedef struct packed {
        pio_pkg::pio_state_t st;
        logic [5:0]          cnt;
        logic                rd;
        logic                blk;
        logic                second;
        logic [15:0]         addr;
        logic [15:0]         wdata;
        logic [15:0]         rdata;
        logic                done;
        logic                spk;
    } pio_con_t;

    pio_con_t s_q;
    pio_con_t s_d;
    logic     mem_hit;
    logic     spk_hit;

    // Selects are decoded from the request and then held in the state.
    pio_decode pio_decode_i (
        .addr    (req_addr),
        .rd      (req_rd),
        .mem_hit (mem_hit),
        .spk_hit (spk_hit)
    );

    // A released data bus reads as zero: data-in high pulls it down,
    // so a card that does not answer yields zero, not stale data.
    logic [7:0] rd_byte;
    assign rd_byte = bus.data_per_oe ? bus.data_per_o : 8'h00;

    // Cycle plan in mclk ticks, counted from the start of each byte or
    // bit cycle. Every count is rounded down to whole ticks except the
    // settle time, which is rounded up so the address never gets less.
    // The trade-off: a byte cycle may end up to one tick short of its
    // typical length, which a card cannot tell from normal spread.
    localparam logic [5:0] SETTLE = 6'(`PIO_SETTLE_CYC);
    localparam logic [5:0] PH2    = 6'(`PIO_PH2_CYC);
    localparam logic [5:0] WREND  = 6'(`PIO_PH2_CYC + `PIO_WRSTB_CYC);
    localparam logic [5:0] SAMPLE = 6'(`PIO_SAMPLE_CYC);
    localparam logic [5:0] BYTE   = 6'(`PIO_BYTE_CYC);
    localparam logic [5:0] ALU    = 6'(`PIO_ALU_CYC);
    localparam logic [5:0] SERSMP = 6'(`PIO_SERSMP_CYC);
    localparam logic [5:0] SERCLK = 6'(`PIO_SERCLK_CYC);
    localparam logic [5:0] SERSTB = 6'(`PIO_SERCLK_CYC + `PIO_SERSTB_CYC);
    localparam logic [5:0] SEREND = 6'(`PIO_SER_CYC);

    // Sequencer: one counter paces every edge of the byte and bit cycles.
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            pio_pkg::PIO_IDLE: begin
                // Capture the whole request; the bus works from the copy.
                if (req) begin
                    s_d.rd     = req_rd;
                    s_d.blk    = mem_hit & ~req_ser;
                    s_d.addr   = req_addr;
                    s_d.wdata  = req_wdata;
                    s_d.second = 1'b0;
                    s_d.cnt    = 6'h00;
                    s_d.spk    = spk_hit & ~req_ser;
                    if (req_ser) begin
                        s_d.st = pio_pkg::PIO_SER;
                    end else if (req_rd) begin
                        s_d.st = pio_pkg::PIO_MEM;
                    end else begin
                        s_d.st = pio_pkg::PIO_ALU;
                    end
                end
            end
            pio_pkg::PIO_ALU: begin
                // Internal arithmetic cycle: nothing moves on the bus yet.
                s_d.cnt = s_q.cnt + 6'h01;
                if (s_q.cnt == ALU - 6'h01) begin
                    s_d.cnt = 6'h00;
                    s_d.st  = pio_pkg::PIO_MEM;
                end
            end
            pio_pkg::PIO_MEM: begin
                s_d.cnt = s_q.cnt + 6'h01;
                // Odd byte lands in the low lane, even byte in the high.
                if (s_q.rd && s_q.cnt == SAMPLE - 6'h01) begin
                    if (s_q.second) begin
                        s_d.rdata[15:8] = rd_byte;
                    end else begin
                        s_d.rdata[7:0] = rd_byte;
                    end
                end
                if (s_q.cnt == BYTE - 6'h01) begin
                    s_d.cnt = 6'h00;
                    if (s_q.second) begin
                        s_d.st = pio_pkg::PIO_DONE;
                    end else begin
                        s_d.second = 1'b1;
                    end
                end
            end
            pio_pkg::PIO_SER: begin
                // One bit cycle; only reads sample the input line.
                s_d.cnt = s_q.cnt + 6'h01;
                if (s_q.rd && s_q.cnt == SERSMP - 6'h01) begin
                    s_d.rdata = {15'h0000, bus.serial_io_in};
                end
                if (s_q.cnt == SEREND - 6'h01) begin
                    s_d.st = pio_pkg::PIO_DONE;
                end
            end
            pio_pkg::PIO_DONE: begin
                // One-cycle completion pulse, then back to idle.
                s_d.done = 1'b1;
                s_d.st   = pio_pkg::PIO_IDLE;
            end
            default: begin
                s_d.st = pio_pkg::PIO_IDLE;
            end
        endcase
    end

    // State register; reset leaves the bus idle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Which kind of cycle the bus is running now.
    logic in_mem;
    logic in_ser;
    assign in_mem = (s_q.st == pio_pkg::PIO_MEM);
    assign in_ser = (s_q.st == pio_pkg::PIO_SER);

    // Pin drive. The lowest address line doubles as serial output data.
    always_comb begin
        bus.addr = 16'h0000;
        if (in_mem) begin
            bus.addr = {s_q.addr[15:1], ~s_q.second};
        end else if (in_ser) begin
            bus.addr = {s_q.addr[14:0], s_q.wdata[0]};
        end
        bus.memory_cycle_enable_n = ~in_mem;
        bus.data_bus_in_strobe    = in_mem & s_q.rd;
        // Held through both bytes, so the select spans the whole word.
        bus.peripheral_block_select_n =
            ~(in_mem && s_q.blk && (s_q.second || s_q.cnt >= PH2));
        bus.write_strobe_n = ~(in_mem && !s_q.rd && s_q.cnt >= PH2
                               && s_q.cnt < WREND && s_q.cnt >= SETTLE);
        // Speech write select waits for settled address and data.
        bus.speech_block_select_n = ~(in_mem && s_q.spk
                                      && (s_q.rd || s_q.cnt >= SETTLE));
        bus.serial_io_strobe_n = ~(in_ser && !s_q.rd && s_q.cnt >= SERCLK
                                   && s_q.cnt < SERSTB);
        // Data is driven only in write byte cycles, one lane per byte.
        bus.data_con_oe = in_mem & ~s_q.rd;
        bus.data_con_o  = s_q.second ? s_q.wdata[15:8] : s_q.wdata[7:0];
    end

    // Handshake outputs come straight from the state.
    assign req_ready = (s_q.st == pio_pkg::PIO_IDLE);
    assign done      = s_q.done;
    assign rdata     = s_q.rdata;
    assign sys_int_n = bus.external_interrupt_request_n;
endmodule

// ===== src/pio_decode.sv
// Console address predecode for card memory and speech selects.
`timescale 1ns/1ps
`include "pio_regs.svh"
module pio_decode (
    // Address and direction.
    input  wire logic [15:0] addr,
    input  wire logic        rd,
    // Decoded selects, active high.
    output logic             mem_hit,
    output logic             spk_hit
);
    // Pure predecode; the console times the selects onto the pins.
    always_comb begin
        mem_hit = (addr[`PIO_MBLK_HI:`PIO_MBLK_LO] == `PIO_MBLK_VAL);
        spk_hit = rd ? (addr[`PIO_SPK_HI:`PIO_SPK_LO] == `PIO_SPK_RD)
                     : (addr[`PIO_SPK_HI:`PIO_SPK_LO] == `PIO_SPK_WR);
    end
endmodule

// ===== src/pio_pkg.sv
// Types used by the console end of the expansion bus.
package pio_pkg;
    typedef enum logic [2:0] {
        PIO_IDLE,
        PIO_ALU,
        PIO_MEM,
        PIO_SER,
        PIO_DONE
    } pio_state_t;
endpackage

// ===== src/pio_regs.svh
// Timing counts, address decodes and field positions for the expansion bus.
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH
// Clock period of mclk in ns.
`define PIO_CLK_NS        20
// Address settle time before a strobe or sample, ns.
`define PIO_SETTLE_NS     100
`define PIO_SETTLE_CYC    ((`PIO_SETTLE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
// Latest read data after cycle start, ns.
`define PIO_RDVALID_NS    750
`define PIO_RDVALID_CYC   (`PIO_RDVALID_NS / `PIO_CLK_NS)
// Byte read sample point: start of cycle 2 (two 333 ns cycles), ns.
`define PIO_SAMPLE_NS     800
`define PIO_SAMPLE_CYC    (`PIO_SAMPLE_NS / `PIO_CLK_NS)
// Phase two leading edge inside cycle 1, ns.
`define PIO_PH2_NS        160
`define PIO_PH2_CYC       (`PIO_PH2_NS / `PIO_CLK_NS)
// Write strobe low time, ns.
`define PIO_WRSTB_NS      650
`define PIO_WRSTB_CYC     (`PIO_WRSTB_NS / `PIO_CLK_NS)
// Byte write length: lowest address changes here, ns.
`define PIO_BYTE_NS       990
`define PIO_BYTE_CYC      (`PIO_BYTE_NS / `PIO_CLK_NS)
// Internal arithmetic cycle ahead of a write, ns.
`define PIO_ALU_NS        340
`define PIO_ALU_CYC       (`PIO_ALU_NS / `PIO_CLK_NS)
// Serial cycle: two clock cycles of 650 ns total, strobe 80 ns.
`define PIO_SER_NS        650
`define PIO_SER_CYC       (`PIO_SER_NS / `PIO_CLK_NS)
`define PIO_SERSMP_NS     330
`define PIO_SERSMP_CYC    (`PIO_SERSMP_NS / `PIO_CLK_NS)
`define PIO_SERSTB_NS     80
`define PIO_SERSTB_CYC    (`PIO_SERSTB_NS / `PIO_CLK_NS)
`define PIO_SERCLK_NS     410
`define PIO_SERCLK_CYC    (`PIO_SERCLK_NS / `PIO_CLK_NS)
// Memory block decode: top three address bits.
`define PIO_MBLK_HI       15
`define PIO_MBLK_LO       13
`define PIO_MBLK_VAL      3'h2
// Speech decode: top six address bits, write and read addresses.
`define PIO_SPK_HI        15
`define PIO_SPK_LO        10
`define PIO_SPK_WR        6'h24
`define PIO_SPK_RD        6'h25
// Serial space for peripherals and per-card block.
`define PIO_SER_BASE_HI   15
`define PIO_SER_BASE_LO   12
`define PIO_SER_PERI      4'h1
`define PIO_SER_CARD_HI   11
`define PIO_SER_CARD_LO   8
`endif
